// file: radio_packet_transaction_fsm_tb.sv
`timescale 1ns/1ns
module radio_packet_transaction_fsm_tb;
  localparam int SLOW = 40;
  localparam int TXS = 0, DONE = 1, RDY = 2, LIM = 3, LOAD = 4, BOTH = 5, IRQ = 6;
  logic        clk = 1'b0, rst_n = 1'b0, act = 1'b0, role = 1'b0, aack = 1'b0, aretx = 1'b0;
  logic        lowr = 1'b0, pe_wr = 1'b0, txq = 1'b0, txna = 1'b0, apay = 1'b0, crc = 1'b0, ack_att = 1'b0;
  logic [3:0]  lim = 4'h0, dly = 4'h0, rcnt;
  logic [5:0]  pe = 6'h00, pe_o, state;
  logic [31:0] up = 32'h0, seed = 32'h635d42cf;
  logic [39:0] a0 = 40'h0, ack_addr = 40'h0, raddr, tx_addr;
  logic [39:0] lows = 40'h1514131211; // Low bytes kept unique
  logic        tx_end, rav, rend, rcrc, rna, rpay, tx_start, is_ack, attach, listen, load;
  logic        done_ev, rdy_ev, lim_ev, irq, crc_o;
  logic [1:0]  rpid;
  logic [2:0]  rx_pipe;
  int          errors = 0, tests_run = 0, cyc = 0, end_cyc = 0, gap = 0, span = 0, q = 0;
  int          n[7] = '{default: 0};
  int          s[7] = '{default: 0};
  // Free-running 10 MHz clock
  always #50 clk = ~clk;
  rpt_txn_fsm #(.P_ACK_WAIT_SLOW_CYC(SLOW)) u_dut (
    .i_clock(clk), .i_rst_n(rst_n), .i_activate(act), .i_receiver_role(role), .i_auto_ack_en(aack),
    .i_auto_retx_en(aretx), .i_crc_en(crc), .i_low_rate(lowr), .i_retry_limit_count(lim),
    .i_retry_delay(dly), .i_pipe_enable_wr(pe_wr), .i_pipe_enable_bits(pe),
    .i_pipe_zero_receive_address(a0), .i_pipe_upper_address(up), .i_pipe_low_bytes(lows),
    .i_txq_nonempty(txq), .i_txq_no_ack(txna), .i_ack_pay_pending(apay), .i_tx_end(tx_end),
    .i_rx_addr_valid(rav), .i_rx_addr(raddr), .i_rx_end(rend), .i_rx_crc_ok(rcrc), .i_rx_no_ack(rna),
    .i_rx_pid(rpid), .i_rx_has_payload(rpay), .o_tx_start(tx_start), .o_tx_is_ack(is_ack),
    .o_ack_pay_attach(attach), .o_tx_addr(tx_addr), .o_rx_listen(listen), .o_rx_load(load),
    .o_rx_pipe(rx_pipe), .o_transmit_done_event(done_ev), .o_receive_ready_event(rdy_ev),
    .o_retry_limit_event(lim_ev), .o_irq(irq), .o_transaction_retry_counter(rcnt),
    .o_pipe_enable_bits(pe_o), .o_crc_en(crc_o), .o_state(state));
  rpt_radio_model u_radio (
    .i_clock(clk), .i_rst_n(rst_n), .i_tx_start(tx_start), .o_tx_end(tx_end), .o_rx_addr_valid(rav),
    .o_rx_addr(raddr), .o_rx_end(rend), .o_rx_crc_ok(rcrc), .o_rx_no_ack(rna), .o_rx_pid(rpid),
    .o_rx_has_payload(rpay));
  // Pulse tally, one edge late, so checks read settled counts
  always @(posedge clk) begin
    cyc     <= cyc + 1;
    n[TXS]  <= n[TXS] + int'(tx_start === 1'b1);
    n[DONE] <= n[DONE] + int'(done_ev === 1'b1);
    n[RDY]  <= n[RDY] + int'(rdy_ev === 1'b1);
    n[LIM]  <= n[LIM] + int'(lim_ev === 1'b1);
    n[LOAD] <= n[LOAD] + int'(load === 1'b1);
    n[BOTH] <= n[BOTH] + int'(done_ev === 1'b1 && rdy_ev === 1'b1);
    n[IRQ]  <= n[IRQ] + int'(irq === 1'b1);
    if (tx_end === 1'b1) end_cyc <= cyc;
    if (tx_start === 1'b1) gap <= cyc - end_cyc;
    if (tx_start === 1'b1 && is_ack === 1'b1) ack_addr <= tx_addr;
    if (tx_start === 1'b1 && is_ack === 1'b1) ack_att <= attach;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Pipe 0 has a full address, the others share the upper bytes
  function automatic logic [39:0] pipe_addr(input int k);
    if (k == 0) return a0;
    return {up, lows[8*(k-1) +: 8]};
  endfunction
  function automatic logic [39:0] d(input int i);
    return 40'(n[i] - s[i]);
  endfunction
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #10;
  endtask
  // Bounded poll of the state, checked at the end
  task automatic wait_st(input logic [5:0] st, input int mx);
    int i;
    i = 0;
    while (state !== st && i < mx) begin
      step(1);
      i++;
    end
    chk(state, st);
  endtask
  task automatic do_reset();
    act   = 1'b0;
    txq   = 1'b0;
    rst_n = 1'b0;
    step(6);
    rst_n = 1'b1;
    s     = n;
  endtask
  task automatic pe_write(input logic [5:0] v);
    pe    = v;
    pe_wr = 1'b1;
    step(1);
    pe_wr = 1'b0;
  endtask
  task automatic end_sim();
    $display("counts: tests_run=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    u_radio.tx_lat = 2 + int'(rnd() % 4);
    up = rnd();
    a0 = {rnd(), 8'ha0}; // Transmit address equals pipe 0 address
    do_reset();
    chk(pe_o, 6'h03);
    crc = 1'b1;
    step(1);
    chk(crc_o, 1'b1);
    crc = 1'b0;
    aretx = 1'b1;
    txna  = 1'b1;
    txq   = 1'b1;
    act   = 1'b1;
    wait_st(6'h02, 10);
    txq = 1'b0;
    wait_st(6'h08, 20);
    chk(d(DONE), 1);
    chk(d(IRQ), 1);
    $display("test no_ack done");
    // Ack with and without payload
    for (int p = 0; p < 2; p++) begin
      do_reset();
      txna = 1'b0;
      txq  = 1'b1;
      act  = 1'b1;
      wait_st(6'h04, 30);
      chk(listen, 1'b1);
      txq = 1'b0;
      u_radio.rx_pkt(a0, 2'h0, 1'b0, p[0]);
      step(3);
      chk(d(DONE), 1);
      chk(d(RDY), p);
      chk(d(BOTH), p);
      chk(d(LOAD), p);
      chk(d(IRQ), 1);
    end
    $display("test ack done");
    // Lost acks up to the limit, slow rate timeout
    do_reset();
    lowr = 1'b1;
    lim  = 4'h1;
    dly  = 4'(rnd() % 2);
    span = (int'(dly) + 1) * 2500;
    txq  = 1'b1;
    act  = 1'b1;
    wait_st(6'h04, 30);
    wait_st(6'h08, SLOW + 10);
    wait_st(6'h02, span + 10);
    step(2);
    chk(40'(gap >= span && gap <= span + 4), 40'h1);
    chk(rcnt, 4'h1);
    wait_st(6'h04, 30);
    wait_st(6'h08, SLOW + 10);
    wait_st(6'h01, span + 10);
    wait_st(6'h02, 10);
    chk(d(LIM), 1);
    chk(rcnt, 4'h0);
    $display("test retry done");
    // Receiver: every pipe, a repeat, ack payload, a disabled pipe, a no-ack packet
    do_reset();
    role  = 1'b1;
    aack  = 1'b1;
    aretx = 1'b0;
    lowr  = 1'b0;
    act   = 1'b1;
    pe_write(6'h3f);
    wait_st(6'h10, 10);
    chk(crc_o, 1'b1);
    chk(pe_o, 6'h3f);
    for (int k = 0; k < 6; k++) begin
      s    = n;
      apay = (k == 5);
      u_radio.rx_pkt(pipe_addr(k), 2'(k), 1'b0, 1'b1);
      wait_st(6'h10, 30);
      chk(d(LOAD), 1);
      chk(d(RDY), 1);
      chk(rx_pipe, 40'(k));
      chk(ack_addr, pipe_addr(k));
      chk(40'(ack_att), 40'(k == 5));
      chk(d(TXS), 1);
    end
    apay = 1'b0;
    s    = n;
    u_radio.rx_pkt(pipe_addr(2), 2'h2, 1'b0, 1'b1);
    wait_st(6'h10, 30);
    chk(d(LOAD), 0);
    chk(d(TXS), 1);
    u_radio.rx_pkt(pipe_addr(5), 2'h2, 1'b0, 1'b1);
    wait_st(6'h10, 30);
    chk(d(DONE), 1);
    q = 1 + int'(rnd() % 5);
    pe_write(6'h3f ^ (6'h01 << q));
    s = n;
    u_radio.rx_pkt(pipe_addr(q), 2'h3, 1'b0, 1'b1);
    step(3);
    u_radio.rx_pkt(pipe_addr(0), 2'h3, 1'b1, 1'b1);
    step(3);
    chk(d(LOAD), 1);
    chk(d(TXS), 0);
    $display("test receiver done");
    end_sim();
  end
  // Watchdog well beyond the longest expected run
  initial begin
    #4000000;
    errors++;
    $display("watchdog expired");
    end_sim();
  end
endmodule // radio_packet_transaction_fsm_tb

// file: rpt_pkg.sv
package rpt_pkg;
  // Clock and timing figures
  localparam int CLK_PERIOD_NS     = 100;
  localparam int RETRY_STEP_NS     = 250000;
  localparam int RETRY_STEP_CYC    = (RETRY_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACK_WAIT_NS       = 250000;
  localparam int ACK_WAIT_CYC      = ACK_WAIT_NS / CLK_PERIOD_NS;
  localparam int ACK_WAIT_SLOW_NS  = 500000;
  localparam int ACK_WAIT_SLOW_CYC = ACK_WAIT_SLOW_NS / CLK_PERIOD_NS;
  // Widths and reset values
  localparam int NUM_PIPES         = 6;
  localparam int ADDR_W            = 40;
  localparam int PID_W             = 2;
  localparam int CNT_W             = 4;
  localparam int TMR_W             = 17;
  localparam logic [5:0] PIPE_EN_RST = 6'h03;
  // Transaction states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE1    = 6'h01,
    ST_TX       = 6'h02,
    ST_WAIT_ACK = 6'h04,
    ST_IDLE2    = 6'h08,
    ST_RX       = 6'h10,
    ST_ACK_TX   = 6'h20
  } rpt_state_t;
endpackage

// file: rpt_radio_model.sv
`timescale 1ns/1ns
// Far-side radio: air time for sends, received packets played in by the bench
module rpt_radio_model (
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_tx_start,
  output logic             o_tx_end,
  output logic             o_rx_addr_valid,
  output logic [39:0]      o_rx_addr,
  output logic             o_rx_end,
  output logic             o_rx_crc_ok,
  output logic             o_rx_no_ack,
  output logic [1:0]       o_rx_pid,
  output logic             o_rx_has_payload
);
  int   tx_lat = 3; // Air time in cycles, varied by the bench
  int   left_q;
  logic busy_q;
  // Countdown of air time; the end is a one-cycle pulse
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_q   <= 1'b0;
      left_q   <= 0;
      o_tx_end <= 1'b0;
    end else if (i_tx_start) begin
      busy_q   <= 1'b1;
      left_q   <= tx_lat;
      o_tx_end <= 1'b0;
    end else begin
      busy_q   <= busy_q && left_q != 0;
      left_q   <= left_q - 1;
      o_tx_end <= busy_q && left_q == 0;
    end
  end
  // Lines outside their pulse show the inverse, so a stale value never matches
  task automatic rx_pkt(input logic [39:0] a, input logic [1:0] pid, input logic na, input logic pay);
    @(posedge i_clock);
    #10;
    o_rx_addr_valid = 1'b1;
    o_rx_addr       = a;
    @(posedge i_clock);
    #10;
    o_rx_addr_valid = 1'b0;
    o_rx_addr       = ~a;
    repeat (4) @(posedge i_clock);
    #10;
    o_rx_end         = 1'b1;
    o_rx_crc_ok      = 1'b1;
    o_rx_no_ack      = na;
    o_rx_pid         = pid;
    o_rx_has_payload = pay;
    @(posedge i_clock);
    #10;
    o_rx_end         = 1'b0;
    o_rx_crc_ok      = 1'b0;
    o_rx_no_ack      = ~na;
    o_rx_pid         = ~pid;
    o_rx_has_payload = ~pay;
  endtask
  // Quiet air at time zero
  initial begin
    o_rx_addr_valid  = 1'b0;
    o_rx_addr        = 40'h0;
    o_rx_end         = 1'b0;
    o_rx_crc_ok      = 1'b0;
    o_rx_no_ack      = 1'b0;
    o_rx_pid         = 2'h0;
    o_rx_has_payload = 1'b0;
  end
endmodule // rpt_radio_model

// file: rpt_txn_fsm.sv
`timescale 1ns/1ns
module rpt_txn_fsm #(
  parameter int P_ACK_WAIT_SLOW_CYC = rpt_pkg::ACK_WAIT_SLOW_CYC
) (
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_activate,
  input  wire logic        i_receiver_role,
  input  wire logic        i_auto_ack_en,
  input  wire logic        i_auto_retx_en,
  input  wire logic        i_crc_en,
  input  wire logic        i_low_rate,
  input  wire logic [3:0]  i_retry_limit_count,
  input  wire logic [3:0]  i_retry_delay,
  input  wire logic        i_pipe_enable_wr,
  input  wire logic [5:0]  i_pipe_enable_bits,
  input  wire logic [39:0] i_pipe_zero_receive_address,
  input  wire logic [31:0] i_pipe_upper_address,
  input  wire logic [39:0] i_pipe_low_bytes,
  input  wire logic        i_txq_nonempty,
  input  wire logic        i_txq_no_ack,
  input  wire logic        i_ack_pay_pending,
  input  wire logic        i_tx_end,
  input  wire logic        i_rx_addr_valid,
  input  wire logic [39:0] i_rx_addr,
  input  wire logic        i_rx_end,
  input  wire logic        i_rx_crc_ok,
  input  wire logic        i_rx_no_ack,
  input  wire logic [1:0]  i_rx_pid,
  input  wire logic        i_rx_has_payload,
  output logic             o_tx_start,
  output logic             o_tx_is_ack,
  output logic             o_ack_pay_attach,
  output logic [39:0]      o_tx_addr,
  output logic             o_rx_listen,
  output logic             o_rx_load,
  output logic [2:0]       o_rx_pipe,
  output logic             o_transmit_done_event,
  output logic             o_receive_ready_event,
  output logic             o_retry_limit_event,
  output logic             o_irq,
  output logic [3:0]       o_transaction_retry_counter,
  output logic [5:0]       o_pipe_enable_bits,
  output logic             o_crc_en,
  output logic [5:0]       o_state
);
  rpt_pkg::rpt_state_t state_q, state_d;
  logic                     act_m_q, act_q;
  logic [5:0]               pipe_en_q;
  logic [rpt_pkg::TMR_W-1:0] tmr_q, delay_cyc, wait_cyc;
  logic [3:0]               cnt_q;
  logic                     noack_q, retry_q, busy_q;
  logic [2:0]               pipe_q, hit_idx;
  logic [5:0]               match, seen_q, paysent_q;
  logic [1:0]               pid_q [rpt_pkg::NUM_PIPES];
  logic [39:0]              pipe_addr [rpt_pkg::NUM_PIPES];
  logic                     pkt_ok, is_new, new_txn, retx;
  logic                     start_d, ack_d, done_d, ready_d, maxrt_d, load_d;

  // Activate pin comes from outside: two flops before use
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      act_m_q <= 1'b0;
      act_q   <= 1'b0;
    end else begin
      act_m_q <= i_activate;
      act_q   <= act_m_q;
    end
  end

  // Pipe enables, pipes 0 and 1 on after reset
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) pipe_en_q <= rpt_pkg::PIPE_EN_RST;
    else if (i_pipe_enable_wr) pipe_en_q <= i_pipe_enable_bits;
  end

  // Pipe addresses and parallel decoders
  for (genvar g = 0; g < rpt_pkg::NUM_PIPES; g++) begin : g_pipe
    if (g == 0) begin : g_zero
      assign pipe_addr[g] = i_pipe_zero_receive_address;
    end else begin : g_rest
      assign pipe_addr[g] = {i_pipe_upper_address, i_pipe_low_bytes[8*(g-1) +: 8]};
    end
    // Acks arrive on pipe 0 only; other pipes listen in receiver role
    assign match[g] = pipe_en_q[g] && (i_rx_addr == pipe_addr[g]) &&
                      (g == 0 || state_q == rpt_pkg::ST_RX);
  end

  // Host keeps addresses unique, so lowest hit is the only hit
  always_comb begin
    hit_idx = 3'h0;
    for (int i = rpt_pkg::NUM_PIPES - 1; i >= 0; i--) begin
      if (match[i]) hit_idx = 3'(i);
    end
  end

  // Receive lock: one pipe owns the air until its packet ends
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_q <= 1'b0;
      pipe_q <= 3'h0;
    end else if (!o_rx_listen || i_rx_end) begin
      busy_q <= 1'b0;
    end else if (i_rx_addr_valid && !busy_q && |match) begin
      busy_q <= 1'b1;
      pipe_q <= hit_idx;
    end
  end

  assign pkt_ok = i_rx_end && busy_q && i_rx_crc_ok;
  // Without auto-ack every packet counts as new
  assign is_new = !i_auto_ack_en || !seen_q[pipe_q] || (pid_q[pipe_q] != i_rx_pid);
  assign delay_cyc = rpt_pkg::TMR_W'((32'(i_retry_delay) + 32'h1) * 32'(rpt_pkg::RETRY_STEP_CYC));
  assign wait_cyc = i_low_rate ? rpt_pkg::TMR_W'(P_ACK_WAIT_SLOW_CYC)
                               : rpt_pkg::TMR_W'(rpt_pkg::ACK_WAIT_CYC);

  // Transaction sequencing
  always_comb begin
    state_d = state_q;
    start_d = 1'b0;
    ack_d   = 1'b0;
    done_d  = 1'b0;
    ready_d = 1'b0;
    maxrt_d = 1'b0;
    load_d  = 1'b0;
    new_txn = 1'b0;
    retx    = 1'b0;
    unique case (state_q)
      rpt_pkg::ST_IDLE1: begin
        if (act_q && i_receiver_role) begin
          state_d = rpt_pkg::ST_RX;
        end else if (act_q && i_txq_nonempty) begin
          state_d = rpt_pkg::ST_TX;
          start_d = 1'b1;
          new_txn = 1'b1;
        end else if (act_q) begin
          state_d = rpt_pkg::ST_IDLE2;
        end
      end
      rpt_pkg::ST_TX: begin
        if (i_tx_end && i_auto_retx_en && !noack_q) begin
          state_d = rpt_pkg::ST_WAIT_ACK;
        end else if (i_tx_end) begin
          done_d  = 1'b1;
          state_d = rpt_pkg::ST_IDLE1;
        end
      end
      rpt_pkg::ST_WAIT_ACK: begin
        if (pkt_ok) begin
          done_d  = 1'b1;
          ready_d = i_rx_has_payload;
          load_d  = i_rx_has_payload;
          state_d = rpt_pkg::ST_IDLE1;
        end else if (i_rx_end || (!busy_q && tmr_q >= wait_cyc)) begin
          state_d = rpt_pkg::ST_IDLE2;
        end
      end
      rpt_pkg::ST_IDLE2: begin
        if (retry_q) begin
          if (tmr_q >= delay_cyc && cnt_q < i_retry_limit_count) begin
            state_d = rpt_pkg::ST_TX;
            start_d = 1'b1;
            retx    = 1'b1;
          end else if (tmr_q >= delay_cyc) begin
            maxrt_d = 1'b1;
            state_d = rpt_pkg::ST_IDLE1;
          end
        end else if (!act_q) begin
          state_d = rpt_pkg::ST_IDLE1;
        end else if (i_txq_nonempty) begin
          state_d = rpt_pkg::ST_TX;
          start_d = 1'b1;
          new_txn = 1'b1;
        end
      end
      rpt_pkg::ST_RX: begin
        if (!act_q) begin
          state_d = rpt_pkg::ST_IDLE1;
        end else if (pkt_ok) begin
          // Repeats are dropped but still acknowledged
          load_d  = is_new;
          ready_d = is_new;
          done_d  = is_new && paysent_q[pipe_q];
          if (i_auto_ack_en && !i_rx_no_ack) begin
            state_d = rpt_pkg::ST_ACK_TX;
            start_d = 1'b1;
            ack_d   = 1'b1;
          end
        end
      end
      rpt_pkg::ST_ACK_TX: begin
        if (i_tx_end) state_d = rpt_pkg::ST_RX;
      end
      default: state_d = rpt_pkg::ST_IDLE1;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) state_q <= rpt_pkg::ST_IDLE1;
    else state_q <= state_d;
  end

  // Timer runs from end of each packet sent in ST_TX (acks sent in ST_ACK_TX do not restart it), saturates
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) tmr_q <= '0;
    else if (state_q == rpt_pkg::ST_TX && i_tx_end) tmr_q <= '0;
    else if (tmr_q != '1) tmr_q <= tmr_q + 1'b1;
  end

  // Retry bookkeeping
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q   <= 4'h0;
      retry_q <= 1'b0;
      noack_q <= 1'b0;
    end else begin
      if (new_txn) cnt_q <= 4'h0;
      else if (retx) cnt_q <= cnt_q + 4'h1;
      if (state_q == rpt_pkg::ST_WAIT_ACK && state_d == rpt_pkg::ST_IDLE2) retry_q <= 1'b1;
      else if (state_d != rpt_pkg::ST_IDLE2) retry_q <= 1'b0;
      if (new_txn) noack_q <= i_txq_no_ack;
    end
  end

  // Duplicate tracking and ack-payload history per pipe
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seen_q    <= 6'h00;
      paysent_q <= 6'h00;
      for (int i = 0; i < rpt_pkg::NUM_PIPES; i++) pid_q[i] <= 2'h0;
    end else if (state_q == rpt_pkg::ST_RX && pkt_ok) begin
      seen_q[pipe_q] <= 1'b1;
      pid_q[pipe_q]  <= i_rx_pid;
      // Clear on report, but a fresh payload ack sets again
      if (ack_d) paysent_q[pipe_q] <= i_ack_pay_pending;
      else if (done_d) paysent_q[pipe_q] <= 1'b0;
    end
  end

  // Registered outputs
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_start            <= 1'b0;
      o_tx_is_ack           <= 1'b0;
      o_ack_pay_attach      <= 1'b0;
      o_tx_addr             <= '0;
      o_rx_listen           <= 1'b0;
      o_rx_load             <= 1'b0;
      o_rx_pipe             <= 3'h0;
      o_transmit_done_event <= 1'b0;
      o_receive_ready_event <= 1'b0;
      o_retry_limit_event   <= 1'b0;
      o_irq                 <= 1'b0;
    end else begin
      o_tx_start            <= start_d;
      o_tx_is_ack           <= ack_d;
      o_ack_pay_attach      <= ack_d && i_ack_pay_pending;
      if (start_d) o_tx_addr <= ack_d ? pipe_addr[pipe_q] : i_pipe_zero_receive_address;
      o_rx_listen           <= state_d == rpt_pkg::ST_RX || state_d == rpt_pkg::ST_WAIT_ACK;
      o_rx_load             <= load_d;
      if (load_d) o_rx_pipe <= pipe_q;
      o_transmit_done_event <= done_d;
      o_receive_ready_event <= ready_d;
      o_retry_limit_event   <= maxrt_d;
      o_irq                 <= done_d || ready_d || maxrt_d;
    end
  end

  assign o_transaction_retry_counter = cnt_q;
  assign o_pipe_enable_bits          = pipe_en_q;
  assign o_state                     = state_q;

  // CRC cannot be off while the enhanced protocol runs
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) o_crc_en <= 1'b0;
    else o_crc_en <= i_crc_en || i_auto_ack_en || i_auto_retx_en;
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  tx_start_a: assert property (state_q == rpt_pkg::ST_IDLE1 && act_q && !i_receiver_role && i_txq_nonempty
    |=> o_tx_start && state_q == rpt_pkg::ST_TX) else $error("queued packet not sent");
  ack_listen_a: assert property (state_q == rpt_pkg::ST_TX && i_tx_end && i_auto_retx_en && !noack_q
    |=> state_q == rpt_pkg::ST_WAIT_ACK && o_rx_listen ##1 o_rx_listen == (state_q == rpt_pkg::ST_WAIT_ACK))
    else $error("no ack listen");
  done_only_a: assert property (state_q == rpt_pkg::ST_WAIT_ACK && pkt_ok && !i_rx_has_payload
    |=> o_transmit_done_event && !o_receive_ready_event) else $error("empty ack events wrong");
  done_ready_a: assert property (state_q == rpt_pkg::ST_WAIT_ACK && pkt_ok && i_rx_has_payload
    |=> o_transmit_done_event && o_receive_ready_event && state_q == rpt_pkg::ST_IDLE1) else $error("payload ack");
  retry_send_a: assert property (state_q == rpt_pkg::ST_IDLE2 && retry_q && tmr_q >= delay_cyc
    && cnt_q < i_retry_limit_count |=> o_tx_start && cnt_q == $past(cnt_q) + 4'h1) else $error("no resend");
  retry_limit_a: assert property (state_q == rpt_pkg::ST_IDLE2 && retry_q && tmr_q >= delay_cyc
    && cnt_q >= i_retry_limit_count |=> o_retry_limit_event && o_irq && state_q == rpt_pkg::ST_IDLE1)
    else $error("retry limit missed");
  empty_wait_a: assert property (state_q == rpt_pkg::ST_IDLE1 && act_q && !i_receiver_role && !i_txq_nonempty
    |=> state_q == rpt_pkg::ST_IDLE2) else $error("empty queue not idle two");
  rx_enter_a: assert property (state_q == rpt_pkg::ST_IDLE1 && act_q && i_receiver_role
    |=> o_rx_listen) else $error("receiver not listening");
  pipe_lock_a: assert property (busy_q && !i_rx_end && o_rx_listen |=> $stable(pipe_q)) else $error("pipe stolen");
  cnt_clear_a: assert property (new_txn |=> cnt_q == 4'h0) else $error("retry counter not cleared");
  event_irq_a: assert property (o_transmit_done_event || o_receive_ready_event |-> o_irq) else $error("no irq");

  retry_path_c: cover property (maxrt_d ##1 o_retry_limit_event && state_q == rpt_pkg::ST_IDLE1);
  payload_ack_c: cover property (o_transmit_done_event && o_receive_ready_event);
  dup_ack_c: cover property (state_q == rpt_pkg::ST_RX && pkt_ok && !is_new && ack_d);
endmodule // rpt_txn_fsm
